// file: three_wire_register_port.v
// Functional notes
// - Write, read request and readback frames are all exactly 26 bits.
// - All frames move most significant bit first, both directions.
// - Frame holds 16-bit data, then 5-bit address, operation code, select.
// - Address zero uses data low byte as subaddress into 256 byte registers.
// - Two-bit operation code picks write, set, clear or read; 00 writes.
// - Set operation forces to one the bits where data holds ones.
// - Clear operation forces to zero the bits where data holds ones.
// - Low three bits select the device; only own select code is acted on.
// - Readback frame uses write layout with data, address, read code, select.
// - Serial data is sampled on every rising serial clock edge of a write or read request frame.
// - Operation commits to the register on the rising enable strobe.
// - Device drives readback once host pulls enable low after the gap.
// - Readback level select bit resets to one, selecting the higher supply.
`timescale 1ns/10ps
`include "three_wire_register_port_consts.vh"

module three_wire_register_port #(
  parameter [2:0] SELECT_CODE = 3'h5 // Arbitrary value
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_serial_clk,
  input wire i_serial_enable_strobe,
  input wire i_serial_data_in,
  output wire o_serial_data_out,
  output wire o_serial_data_oe,
  output wire o_readback_level_select,
  output wire o_commit_pulse,
  output wire o_discard_pulse
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [2:0] sclk_q;
  reg [2:0] en_q;
  reg [1:0] sdi_q;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sclk_q <= 3'h0;
      en_q <= 3'h7;
      sdi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], i_serial_clk};
      en_q <= {en_q[1:0], i_serial_enable_strobe};
      sdi_q <= {sdi_q[0], i_serial_data_in};
    end
  end

  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire en_low = ~en_q[1];
  wire en_rise = en_q[1] & ~en_q[2];
  wire en_fall = ~en_q[1] & en_q[2];

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [15:0] word_mem [1:`WORD_REGS];
  reg [7:0] byte_mem [0:`BYTE_REGS-1];

  function [15:0] apply_op;
    input [1:0] op;
    input [15:0] old_val;
    input [15:0] val;
    begin
      case (op)
        `OP_WRITE: apply_op = val;
        `OP_SET: apply_op = old_val | val;
        `OP_CLEAR: apply_op = old_val & ~val;
        default: apply_op = old_val;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Frame shifter and decode
  // ----------------------------------------
  reg [`FRAME_BITS-1:0] shift_q;
  reg [`FRAME_CNT_W-1:0] cnt_q;
  reg rb_pending_q;
  reg rb_active_q;
  reg [`FRAME_BITS-1:0] rb_shift_q;
  reg [`FRAME_CNT_W-1:0] rb_cnt_q;
  reg sdo_q;
  reg oe_q;
  reg commit_q;
  reg discard_q;
  reg rb_busy_q;

  wire [15:0] f_data = shift_q[`DATA_HI:`DATA_LO];
  wire [4:0] f_addr = shift_q[`ADDR_HI:`ADDR_LO];
  wire [1:0] f_op = shift_q[`OP_HI:`OP_LO];
  wire [2:0] f_sel = shift_q[`SEL_HI:`SEL_LO];
  wire [7:0] f_sub = f_data[7:0];
  wire [7:0] f_byte = f_data[15:8];
  wire is_byte = (f_addr == `ADDR_BYTE_SPACE);

  // Frame is good only with full length and own select code
  wire frame_ok = (cnt_q == `FRAME_BITS) && (f_sel == SELECT_CODE);
  wire do_commit = en_rise && !rb_busy_q && frame_ok;
  wire do_discard = en_rise && !rb_busy_q && !frame_ok;

  // Readback word, padding of request ignored
  wire [15:0] rd_val = is_byte ? {byte_mem[f_sub], f_sub} : word_mem[f_addr];
  wire [`FRAME_BITS-1:0] rb_frame = {rd_val, f_addr, `OP_READ, f_sel};

  // Byte registers keep only the low half of the operation result
  wire [15:0] byte_next = apply_op(f_op, {8'h00, byte_mem[f_sub]}, {8'h00, f_byte});

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      shift_q <= {`FRAME_BITS{1'b0}};
      cnt_q <= {`FRAME_CNT_W{1'b0}};
    end else if (en_fall) begin
      cnt_q <= {`FRAME_CNT_W{1'b0}};
    end else if (en_low && !rb_busy_q && sclk_rise) begin
      shift_q <= {shift_q[`FRAME_BITS-2:0], sdi_q[1]};
      if (cnt_q != {`FRAME_CNT_W{1'b1}}) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  integer i;
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (i = 1; i <= `WORD_REGS; i = i + 1) begin
        word_mem[i] <= `WORD_RST;
      end
      word_mem[`ADDR_LEVEL_REG] <= `LEVEL_REG_RST;
      for (i = 0; i < `BYTE_REGS; i = i + 1) begin
        byte_mem[i] <= `BYTE_RST;
      end
    end else if (do_commit && f_op != `OP_READ) begin
      if (is_byte) begin
        byte_mem[f_sub] <= byte_next[7:0];
      end else begin
        word_mem[f_addr] <= apply_op(f_op, word_mem[f_addr], f_data);
      end
    end
  end

  // ----------------------------------------
  // Readback sequencer
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rb_pending_q <= 1'b0;
      rb_active_q <= 1'b0;
      rb_shift_q <= {`FRAME_BITS{1'b0}};
      rb_cnt_q <= {`FRAME_CNT_W{1'b0}};
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (rb_active_q) begin
      if (en_rise || rb_cnt_q == `FRAME_BITS) begin
        rb_active_q <= 1'b0;
        oe_q <= 1'b0;
        sdo_q <= 1'b0;
      end else begin
        if (sclk_rise) begin
          rb_cnt_q <= rb_cnt_q + 5'h01;
        end
        if (sclk_fall) begin
          rb_shift_q <= {rb_shift_q[`FRAME_BITS-2:0], 1'b0};
          sdo_q <= rb_shift_q[`FRAME_BITS-2];
        end
      end
    end else if (do_commit && f_op == `OP_READ) begin
      rb_pending_q <= 1'b1;
      rb_shift_q <= rb_frame;
    end else if (do_discard) begin
      rb_pending_q <= 1'b0;
    end else if (rb_pending_q && en_fall) begin
      // Host has let go of the line during the gap
      rb_pending_q <= 1'b0;
      rb_active_q <= 1'b1;
      rb_cnt_q <= {`FRAME_CNT_W{1'b0}};
      oe_q <= 1'b1;
      sdo_q <= rb_shift_q[`FRAME_BITS-1];
    end
  end

  // ----------------------------------------
  // Readback window ownership
  // ----------------------------------------
  // Closing strobe of a readback is no host frame
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rb_busy_q <= 1'b0;
    end else if (en_rise) begin
      rb_busy_q <= 1'b0;
    end else if (rb_pending_q && en_fall) begin
      rb_busy_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Status pulses
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      commit_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      commit_q <= do_commit;
      discard_q <= do_discard;
    end
  end

  assign o_serial_data_out = sdo_q;
  assign o_serial_data_oe = oe_q;
  assign o_readback_level_select = word_mem[`ADDR_LEVEL_REG][`LEVEL_BIT];
  assign o_commit_pulse = commit_q;
  assign o_discard_pulse = discard_q;

endmodule // three_wire_register_port

// file: three_wire_register_port_consts.vh
`ifndef THREE_WIRE_REGISTER_PORT_CONSTS_VH
`define THREE_WIRE_REGISTER_PORT_CONSTS_VH

// Frame geometry
`define FRAME_BITS 26
`define FRAME_CNT_W 5
`define DATA_HI 25
`define DATA_LO 10
`define ADDR_HI 9
`define ADDR_LO 5
`define OP_HI 4
`define OP_LO 3
`define SEL_HI 2
`define SEL_LO 0

// Operation codes
`define OP_WRITE 2'h0
`define OP_SET 2'h1
`define OP_CLEAR 2'h2
`define OP_READ 2'h3

// Register space
`define WORD_REGS 31
`define BYTE_REGS 256
`define ADDR_BYTE_SPACE 5'h00
`define ADDR_LEVEL_REG 5'h02
`define LEVEL_BIT 1
`define WORD_RST 16'h0000
`define LEVEL_REG_RST 16'h0002
`define BYTE_RST 8'h00

`endif

// file: three_wire_register_port_assertions.sv
`timescale 1ns/10ps
module three_wire_register_port_chk (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_serial_clk,
  input wire i_serial_enable_strobe,
  input wire o_serial_data_out,
  input wire o_serial_data_oe,
  input wire o_readback_level_select,
  input wire o_commit_pulse,
  input wire o_discard_pulse
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  pulse_excl_a: assert property (!(o_commit_pulse && o_discard_pulse)) else $error("both pulses");
  commit_one_a: assert property (o_commit_pulse |=> !o_commit_pulse) else $error("long commit");
  commit_edge_a: assert property (o_commit_pulse |-> i_serial_enable_strobe && !$past(i_serial_enable_strobe, 8))
    else $error("commit off strobe");
  oe_start_a: assert property ($rose(o_serial_data_oe) |-> !i_serial_enable_strobe) else $error("early oe");
  oe_free_a: assert property ($rose(i_serial_enable_strobe) |-> ##[1:8] !o_serial_data_oe) else $error("oe held");
  bit_hold_a: assert property (o_serial_data_oe && $past(o_serial_data_oe) && $changed(o_serial_data_out)
    |-> !i_serial_clk) else $error("bit moved");
  out_idle_a: assert property (!o_serial_data_oe |-> !o_serial_data_out) else $error("out not idle");
  level_rst_a: assert property (disable iff (1'b0) i_sys_rst |=> o_readback_level_select) else $error("level");
  rst_quiet_a: assert property (disable iff (1'b0) i_sys_rst |=> !o_serial_data_oe && !o_commit_pulse) else $error("rst");
endmodule // three_wire_register_port_chk
bind three_wire_register_port three_wire_register_port_chk chk (.i_clk_sys, .i_sys_rst, .i_serial_clk,
  .i_serial_enable_strobe, .o_serial_data_out, .o_serial_data_oe, .o_readback_level_select, .o_commit_pulse,
  .o_discard_pulse);

// file: three_wire_register_port_host.sv
`timescale 1ns/10ps
module three_wire_register_port_host (
  input wire i_data_out,
  input wire i_data_oe,
  output logic o_sclk,
  output logic o_strobe,
  output wire o_line
);
  logic drive_q;
  logic bit_q;
  // Released line shows inverse of last bit
  assign o_line = i_data_oe ? i_data_out : (drive_q ? bit_q : ~bit_q);
  initial begin
    o_sclk = 0;
    o_strobe = 1;
    drive_q = 1;
    bit_q = 0;
  end
  task automatic xfer(input logic [25:0] w, input int n, input logic drv, output logic [25:0] r);
    drive_q = drv;
    r = '0;
    o_strobe = 0;
    for (int i = n - 1; i >= 0; i--) begin
      if (drv) bit_q = w[i];
      #62.5 o_sclk = 1;
      r = {r[24:0], o_line};
      #62.5 o_sclk = 0;
    end
    #62.5 o_strobe = 1;
    if (drv && w[4:3] == 2'h3) drive_q = 0;
  endtask
endmodule // three_wire_register_port_host

// file: three_wire_register_port_test.sv
`timescale 1ns/10ps
`include "three_wire_register_port_consts.vh"
module three_wire_register_port_test;
  localparam logic [2:0] SEL = 3'h3;
  logic clk = 0;
  logic rst = 1;
  wire sclk, stb, line, dout, doe, lvl, cmt, dsc;
  int error_cnt = 0, n_compared = 0, cyc = 0, n_dsc = 0, n_cmt = 0, d0;
  logic [25:0] rb;
  initial forever #5 clk = ~clk;
  three_wire_register_port #(.SELECT_CODE(SEL)) dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_serial_clk(sclk),
    .i_serial_enable_strobe(stb), .i_serial_data_in(line), .o_serial_data_out(dout), .o_serial_data_oe(doe),
    .o_readback_level_select(lvl), .o_commit_pulse(cmt), .o_discard_pulse(dsc));
  three_wire_register_port_host host (.i_data_out(dout), .i_data_oe(doe), .o_sclk(sclk), .o_strobe(stb),
    .o_line(line));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dsc === 1'b1) n_dsc++;
    if (cmt === 1'b1) n_cmt++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [25:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] op, input logic [4:0] a, input logic [15:0] d, input logic [2:0] s = SEL,
    input int n = 26);
    @(posedge clk) #1;
    host.xfer({d, a, op, s}, n, 1'b1, rb);
    #100;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] sub, input logic [15:0] exp);
    wr(`OP_READ, a, {8'hC5, sub});
    #300;
    host.xfer(26'h0, 26, 1'b0, rb);
    chk("readback", rb, {exp, a, `OP_READ, SEL});
    #100;
    chk("oe", {25'h0, doe}, 26'h0);
  endtask
  task t_level;
    chk("level", {25'h0, lvl}, 26'h1);
    rd(`ADDR_LEVEL_REG, 8'h00, `LEVEL_REG_RST);
    wr(`OP_CLEAR, `ADDR_LEVEL_REG, 16'h0002);
    chk("level", {25'h0, lvl}, 26'h0);
    wr(`OP_SET, `ADDR_LEVEL_REG, 16'h0002);
    chk("level", {25'h0, lvl}, 26'h1);
    $display("t_level done");
  endtask
  task t_word;
    d0 = n_cmt;
    wr(`OP_WRITE, 5'h05, 16'hA5C3);
    rd(5'h05, 8'h00, 16'hA5C3);
    wr(`OP_SET, 5'h05, 16'h0F0F);
    rd(5'h05, 8'h00, 16'hAFCF);
    wr(`OP_CLEAR, 5'h05, 16'h00FF);
    rd(5'h05, 8'h00, 16'hAF00);
    chk("commits", 26'(n_cmt - d0), 26'h6);
    $display("t_word done");
  endtask
  task t_byte;
    wr(`OP_WRITE, `ADDR_BYTE_SPACE, 16'h3C90);
    rd(`ADDR_BYTE_SPACE, 8'h90, 16'h3C90);
    wr(`OP_SET, `ADDR_BYTE_SPACE, 16'h4190);
    rd(`ADDR_BYTE_SPACE, 8'h90, 16'h7D90);
    $display("t_byte done");
  endtask
  task t_discard;
    d0 = n_dsc;
    wr(`OP_WRITE, 5'h05, 16'h1234, 3'h1);
    wr(`OP_WRITE, 5'h05, 16'h1234, SEL, 25);
    chk("discards", 26'(n_dsc - d0), 26'h2);
    rd(5'h05, 8'h00, 16'hAF00);
    $display("t_discard done");
  endtask
  task t_reset;
    wr(`OP_CLEAR, `ADDR_LEVEL_REG, 16'h0002);
    chk("level", {25'h0, lvl}, 26'h0);
    @(posedge clk) #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    repeat (5) @(posedge clk);
    #1;
    chk("level", {25'h0, lvl}, 26'h1);
    rd(5'h05, 8'h00, `WORD_RST);
    $display("t_reset done");
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    repeat (5) @(posedge clk);
    t_level;
    t_word;
    t_byte;
    t_discard;
    t_reset;
    print_verdict();
  end
endmodule // three_wire_register_port_test
